// ==== hw/bank_close_pkg.sv ====
// Constants for the bank-closing and refresh timing block.
// Assumes a 10 MHz command clock; all times rounded to whole cycles.
package bank_close_pkg;

    localparam int CLK_PERIOD_PS = 100000;

    // Analog times in picoseconds, as printed or plain defaults; RTP_FLOOR_CLKS and PREFETCH_GAP_CLKS in clocks
    localparam int READ_TO_PRECHARGE_PS  = 7500;
    localparam int PRECHARGE_PERIOD_PS   = 15000;
    localparam int ROW_ACTIVE_MIN_PS     = 45000;
    localparam int POST_BURST_RECOVERY_PS = 15000;
    localparam int REFRESH_CYCLE_PS      = 75000;
    localparam int CLOCK_ENABLE_MIN_PS   = 7500;
    localparam int RTP_FLOOR_CLKS        = 2;
    localparam int PREFETCH_GAP_CLKS     = 2;

    function automatic int round_up(input int ps);
        int c;
        c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int RTP_RAW_CLKS  = round_up(READ_TO_PRECHARGE_PS);
    localparam int RTP_CLKS      = (RTP_RAW_CLKS > RTP_FLOOR_CLKS) ? RTP_RAW_CLKS : RTP_FLOOR_CLKS;
    localparam int RP_CLKS       = round_up(PRECHARGE_PERIOD_PS);
    localparam int RAS_CLKS      = round_up(ROW_ACTIVE_MIN_PS);
    localparam int WR_CLKS       = round_up(POST_BURST_RECOVERY_PS);
    localparam int RFC_CLKS      = round_up(REFRESH_CYCLE_PS);
    localparam int CKE_MIN_CLKS  = round_up(CLOCK_ENABLE_MIN_PS);

    localparam int NUM_BANKS = 4;
    localparam int CNT_W     = 8;

    // Mode values, plain defaults
    localparam logic [2:0] ADDITIVE_LATENCY = 3'h1;
    localparam logic [2:0] COLUMN_LATENCY   = 3'h3;
    localparam logic [3:0] BURST_LENGTH     = 4'h4;

    // Command codes {ras_n, cas_n, we_n}
    localparam logic [2:0] CMD_REFRESH   = 3'h1;
    localparam logic [2:0] CMD_PRECHARGE = 3'h2;
    localparam logic [2:0] CMD_ACTIVATE  = 3'h3;
    localparam logic [2:0] CMD_WRITE     = 3'h4;
    localparam logic [2:0] CMD_READ      = 3'h5;

    typedef enum logic [1:0] {
        SR_IDLE   = 2'h0,
        SR_ACTIVE = 2'h1,
        SR_DONE   = 2'h3
    } self_rfsh_state_type;

endpackage

// ==== hw/bank_timer.sv ====
// One bank's auto-precharge and row timing tracker.
// Assumes decoded one-cycle command strobes from the top level.
`timescale 1ns/100ps
module bank_timer
    import bank_close_pkg::*;
(
    input  wire logic             clock_i,
    input  wire logic             reset_i,
    input  wire logic             activate_i,
    input  wire logic             precharge_i,
    input  wire logic             read_ap_i,
    input  wire logic             write_ap_i,
    input  wire logic [CNT_W-1:0] read_ap_edge_i,
    input  wire logic [CNT_W-1:0] write_ap_edge_i,
    output logic                  open_o,
    output logic                  precharging_o,
    output logic                  auto_precharge_o
);

    logic [CNT_W-1:0] ras_count;
    logic [CNT_W-1:0] rtp_count;
    logic [CNT_W-1:0] ap_count;
    logic [CNT_W-1:0] rp_count;
    logic             ap_pending;
    logic             ras_met;
    logic             rtp_met;
    logic             ap_fire;

    assign ras_met = (ras_count == '0);
    assign rtp_met = (rtp_count == '0);
    assign ap_fire = ap_pending && (ap_count == '0) && ras_met && rtp_met;
    assign auto_precharge_o = ap_fire;
    assign precharging_o    = (rp_count != '0);

    // ---------------------------------------------------------------
    // Row active minimum
    // ---------------------------------------------------------------
    // whole-cycle row timers
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            ras_count <= '0;
        end else if (activate_i) begin
            ras_count <= CNT_W'(RAS_CLKS - 1);
        end else if (!ras_met) begin
            ras_count <= ras_count - 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // Auto-precharge scheduling
    // ---------------------------------------------------------------
    // read-to-precharge counts past last prefetch
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            rtp_count <= '0;
        end else if (read_ap_i) begin
            rtp_count <= read_ap_edge_i;
        end else if (!rtp_met) begin
            rtp_count <= rtp_count - 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            ap_pending <= 1'b0;
            ap_count   <= '0;
        end else if (read_ap_i) begin
            ap_pending <= 1'b1;
            ap_count   <= read_ap_edge_i;
        end else if (write_ap_i) begin
            ap_pending <= 1'b1;
            ap_count   <= write_ap_edge_i;
        end else if (ap_fire) begin
            ap_pending <= 1'b0;
        end else if (ap_count != '0) begin
            ap_count <= ap_count - 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // Open row and precharge period
    // ---------------------------------------------------------------
    // period counted from the internal moment
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            rp_count <= '0;
        end else if (ap_fire || (precharge_i && open_o)) begin
            rp_count <= CNT_W'(RP_CLKS);
        end else if (precharging_o) begin
            rp_count <= rp_count - 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            open_o <= 1'b0;
        end else if (activate_i) begin
            open_o <= 1'b1;
        end else if (ap_fire || precharge_i) begin
            open_o <= 1'b0;
        end
    end

endmodule

// ==== hw/bank_close_timing.sv ====
// Command decode, auto-precharge, refresh and self-refresh tracking.
// Assumes a controller that honours its own spacing; pins sampled
// synchronously on clock_i.
`timescale 1ns/100ps
import bank_close_pkg::*;

// Function
// - address bit selects automatic precharge
// - read auto-precharge at additive latency plus half burst
// - postpone until row and read minimums met
// - precharge period starts at internal moment
// - never before two clocks past prefetch
// - write auto-precharge after burst plus recovery
// - refresh decode, internal bank counter, banks idle
// - internal refresh within clock enable minimum
module bank_close_timing
    import bank_close_pkg::*;
(
    input  wire logic                 clock_i,
    input  wire logic                 reset_i,
    input  wire logic                 clock_enable_i,
    input  wire logic                 chip_select_n_i,
    input  wire logic                 row_strobe_n_i,
    input  wire logic                 column_strobe_n_i,
    input  wire logic                 write_enable_n_i,
    input  wire logic [1:0]           bank_address_i,
    input  wire logic                 autoprecharge_select_bit_i,
    output logic [NUM_BANKS-1:0]      bank_open_o,
    output logic [NUM_BANKS-1:0]      bank_precharging_o,
    output logic [NUM_BANKS-1:0]      auto_precharge_start_o,
    output logic                      refresh_busy_o,
    output logic [1:0]                refresh_bank_o,
    output logic                      self_refresh_o,
    output logic                      internal_refresh_o
);

    logic [2:0]           cmd;
    logic                 cmd_valid;
    logic                 clock_enable_prev;
    logic [NUM_BANKS-1:0] bank_sel;
    logic                 is_activate;
    logic                 is_precharge;
    logic                 is_precharge_all;
    logic                 is_read_ap;
    logic                 is_write_ap;
    logic                 is_refresh;
    logic                 is_self_entry;
    logic [CNT_W-1:0]     read_ap_edge;
    logic [CNT_W-1:0]     write_ap_edge;
    logic [CNT_W-1:0]     rfc_count;
    logic [CNT_W-1:0]     sr_count;
    self_rfsh_state_type  sr_state;
    self_rfsh_state_type  next_sr_state;

    // ---------------------------------------------------------------
    // Command decode
    // ---------------------------------------------------------------
    assign cmd       = {row_strobe_n_i, column_strobe_n_i, write_enable_n_i};
    assign cmd_valid = !chip_select_n_i && clock_enable_prev && sr_state == SR_IDLE;
    assign bank_sel  = NUM_BANKS'(1) << bank_address_i;

    assign is_activate      = cmd_valid && clock_enable_i && cmd == CMD_ACTIVATE;
    assign is_precharge     = cmd_valid && clock_enable_i && cmd == CMD_PRECHARGE;
    // Precharge-all shares the select bit with single-bank precharge
    assign is_precharge_all = is_precharge && autoprecharge_select_bit_i;
    // select bit sampled with column command
    assign is_read_ap  = cmd_valid && clock_enable_i && cmd == CMD_READ
                         && autoprecharge_select_bit_i;
    assign is_write_ap = cmd_valid && clock_enable_i && cmd == CMD_WRITE
                         && autoprecharge_select_bit_i;
    assign is_refresh    = cmd_valid && clock_enable_i && cmd == CMD_REFRESH;
    // same encoding with clock enable low
    assign is_self_entry = cmd_valid && !clock_enable_i && cmd == CMD_REFRESH;

    // edge at additive latency plus half burst
    // floor of two clocks past last prefetch
    assign read_ap_edge = CNT_W'(ADDITIVE_LATENCY) + CNT_W'(BURST_LENGTH >> 1) - 1'b1
                        + CNT_W'(RTP_CLKS - RTP_FLOOR_CLKS);
    // write latency plus half burst plus recovery
    assign write_ap_edge = CNT_W'(ADDITIVE_LATENCY) + CNT_W'(COLUMN_LATENCY) - 1'b1
                         + CNT_W'(BURST_LENGTH >> 1) + CNT_W'(WR_CLKS) - 1'b1;

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            clock_enable_prev <= 1'b1;
        end else begin
            clock_enable_prev <= clock_enable_i;
        end
    end

    // ---------------------------------------------------------------
    // Per-bank timers
    // ---------------------------------------------------------------
    for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
        bank_timer u_bank (
            .clock_i          (clock_i),
            .reset_i          (reset_i),
            .activate_i       (is_activate && bank_sel[b]),
            .precharge_i      (is_precharge && (is_precharge_all || bank_sel[b])),
            .read_ap_i        (is_read_ap && bank_sel[b]),
            .write_ap_i       (is_write_ap && bank_sel[b]),
            .read_ap_edge_i   (read_ap_edge),
            .write_ap_edge_i  (write_ap_edge),
            .open_o           (bank_open_o[b]),
            .precharging_o    (bank_precharging_o[b]),
            .auto_precharge_o (auto_precharge_start_o[b])
        );
    end

    // ---------------------------------------------------------------
    // Auto-refresh
    // ---------------------------------------------------------------
    // internal bank counter, banks left idle
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            refresh_bank_o <= 2'h0;
        end else if (is_refresh || internal_refresh_o) begin
            refresh_bank_o <= refresh_bank_o + 2'h1;
        end
    end

    // refresh cycle held in whole clocks
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            rfc_count <= '0;
        end else if (is_refresh || internal_refresh_o) begin
            rfc_count <= CNT_W'(RFC_CLKS);
        end else if (rfc_count != '0) begin
            rfc_count <= rfc_count - 1'b1;
        end
    end

    assign refresh_busy_o = (rfc_count != '0);

    // ---------------------------------------------------------------
    // Self-refresh
    // ---------------------------------------------------------------
    always_comb begin
        next_sr_state = sr_state;
        unique case (sr_state)
            SR_IDLE: begin
                if (is_self_entry) begin
                    next_sr_state = SR_ACTIVE;
                end
            end
            SR_ACTIVE: begin
                if (sr_count == '0) begin
                    next_sr_state = SR_DONE;
                end
            end
            SR_DONE: begin
                // Exit only on clock enable high; clock may have stopped
                if (clock_enable_i) begin
                    next_sr_state = SR_IDLE;
                end
            end
            default: begin
                next_sr_state = SR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            sr_state <= SR_IDLE;
        end else begin
            sr_state <= next_sr_state;
        end
    end

    // refresh fired within clock enable minimum
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            sr_count <= '0;
        end else if (is_self_entry) begin
            sr_count <= CNT_W'(CKE_MIN_CLKS - 1);
        end else if (sr_state == SR_ACTIVE && sr_count != '0) begin
            sr_count <= sr_count - 1'b1;
        end
    end

    // One refresh registered the cycle after entry keeps it inside the minimum
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            internal_refresh_o <= 1'b0;
        end else begin
            internal_refresh_o <= is_self_entry;
        end
    end

    assign self_refresh_o = (sr_state != SR_IDLE);

endmodule

// ==== dv/bank_close_monitor.sv ====
// Checker bound to bank_close_timing, watching its ports only.
// Assumes command pins settle before each rising clock_i.
`timescale 1ns/100ps
module bank_close_monitor
    import bank_close_pkg::*;
(
    input wire logic                 clock_i,
    input wire logic                 reset_i,
    input wire logic                 clock_enable_i,
    input wire logic                 chip_select_n_i,
    input wire logic                 row_strobe_n_i,
    input wire logic                 column_strobe_n_i,
    input wire logic                 write_enable_n_i,
    input wire logic [1:0]           bank_address_i,
    input wire logic                 autoprecharge_select_bit_i,
    input wire logic [NUM_BANKS-1:0] bank_open_o,
    input wire logic [NUM_BANKS-1:0] bank_precharging_o,
    input wire logic [NUM_BANKS-1:0] auto_precharge_start_o,
    input wire logic                 refresh_busy_o,
    input wire logic [1:0]           refresh_bank_o,
    input wire logic                 self_refresh_o,
    input wire logic                 internal_refresh_o
);
    // ----------------
    // Command decode
    // ----------------
    logic cke_q;
    always_ff @(posedge clock_i) begin
        cke_q <= clock_enable_i;
    end
    wire logic [2:0] cmd = {row_strobe_n_i, column_strobe_n_i, write_enable_n_i};
    wire logic live = !chip_select_n_i && cke_q && !self_refresh_o;
    wire logic run = live && clock_enable_i;
    wire logic b0 = bank_address_i == 2'h0;
    wire logic ap = autoprecharge_select_bit_i;
    wire logic rd = run && cmd == CMD_READ;
    wire logic wr = run && cmd == CMD_WRITE;
    wire logic pre = run && cmd == CMD_PRECHARGE;
    wire logic rf = run && cmd == CMD_REFRESH;
    wire logic sre = live && !clock_enable_i && cmd == CMD_REFRESH;
    wire logic [NUM_BANKS-1:0] aps = auto_precharge_start_o;

    default clocking @(posedge clock_i); endclocking
    default disable iff (reset_i);

    // ----------------
    // Assertions
    // ----------------
    rd_ap_start_a:
        assert property (rd && ap && b0 |-> ##[2:8] aps[0]) else $error("read ap late");
    rd_ap_early_a:
        assert property (rd && ap && b0 |=> !aps[0]) else $error("read ap early");
    plain_rd_open_a:
        assert property (rd && !ap && bank_address_i == 2'h1 |=>
            (bank_open_o[1] && !aps[1])[*4]) else $error("plain read closed bank");
    wr_ap_start_a:
        assert property (wr && ap && b0 |-> ##1 (!aps[0])[*3] ##[1:5] aps[0])
            else $error("write ap timing");
    ap_closes_a:
        assert property (aps[0] |=> !bank_open_o[0] && bank_precharging_o[0])
            else $error("no precharge after start");
    pre_all_a:
        assert property (pre && ap |=> bank_open_o == '0) else $error("bank left open");
    ref_idle_a:
        assert property (rf |=> bank_open_o == '0 && refresh_busy_o &&
            !$stable(refresh_bank_o)) else $error("refresh result");
    sr_entry_a:
        assert property (sre |=> self_refresh_o) else $error("no self refresh");
    sr_pulse_a:
        assert property (sre |=> internal_refresh_o ##1 !internal_refresh_o)
            else $error("internal refresh pulse");
    sr_hold_a:
        assert property (self_refresh_o && !clock_enable_i |=> self_refresh_o)
            else $error("self refresh dropped");
    sr_ignore_a:
        assert property (self_refresh_o |=> $stable(bank_open_o)) else $error("cmd taken");

    cover property (rd && ap && b0);
    cover property (rf);
    cover property (sre);
endmodule

bind bank_close_timing bank_close_monitor mon (.*);

// ==== dv/ctl_model.sv ====
// Memory controller model driving the command pins.
// Assumes the bench calls send; pins move 1 ns after clock_i rises.
`timescale 1ns/100ps
module ctl_model
    import bank_close_pkg::*;
(
    input  wire logic       clock_i,
    output logic            clock_enable_o,
    output logic            chip_select_n_o,
    output logic            row_strobe_n_o,
    output logic            column_strobe_n_o,
    output logic            write_enable_n_o,
    output logic [1:0]      bank_address_o,
    output logic            autoprecharge_select_bit_o
);
    int cyc = 0;
    int last = 0;
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
    end
    initial begin
        clock_enable_o = 1'b1;
        chip_select_n_o = 1'b1;
        {row_strobe_n_o, column_strobe_n_o, write_enable_n_o,
            bank_address_o, autoprecharge_select_bit_o} = 6'h3F;
    end

    // ----------------
    // Command issue
    // ----------------
    task automatic send(input logic [2:0] c, input logic [1:0] b, input logic a,
                        input logic k, input int g);
        while (cyc - last < g) @(posedge clock_i);
        @(posedge clock_i);
        #1;
        clock_enable_o = k;
        chip_select_n_o = 1'b0;
        {row_strobe_n_o, column_strobe_n_o, write_enable_n_o} = c;
        {bank_address_o, autoprecharge_select_bit_o} = {b, a};
        last = cyc;
        @(posedge clock_i);
        #1;
        chip_select_n_o = 1'b1;
        // Deselected pins show no stale value
        {row_strobe_n_o, column_strobe_n_o, write_enable_n_o,
            bank_address_o, autoprecharge_select_bit_o} = ~{row_strobe_n_o,
            column_strobe_n_o, write_enable_n_o, bank_address_o, autoprecharge_select_bit_o};
    endtask
endmodule

// ==== dv/bank_close_timing_tb_top.sv ====
// Self-checking bench for bank_close_timing with a controller model.
// Assumes package defaults: every analog time fits in one clock.
`timescale 1ns/100ps
module bank_close_timing_tb_top
    import bank_close_pkg::*;
;
    localparam int G = 8;
    // Pulse index in wait_pulse equals the start edge after the command
    localparam int RD_EDGE = int'(ADDITIVE_LATENCY) + int'(BURST_LENGTH) / 2;
    localparam int PF_EDGE = int'(ADDITIVE_LATENCY) + PREFETCH_GAP_CLKS;
    localparam int WR_EDGE = int'(ADDITIVE_LATENCY) + int'(COLUMN_LATENCY) - 1
                           + int'(BURST_LENGTH) / 2 + WR_CLKS;
    logic                 clock_i;
    logic                 reset_i;
    wire logic            cke;
    wire logic            cs_n;
    wire logic            ras_n;
    wire logic            cas_n;
    wire logic            we_n;
    wire logic [1:0]      bank;
    wire logic            ap;
    logic [3:0]           bank_open;
    logic [3:0]           bank_prech;
    logic [3:0]           ap_start;
    logic                 refresh_busy;
    logic [1:0]           refresh_bank;
    logic                 self_refresh;
    logic                 internal_refresh;
    int                   bad_count = 0;
    int                   total_checks = 0;
    int                   k;

    ctl_model ctl (.clock_i(clock_i), .clock_enable_o(cke), .chip_select_n_o(cs_n),
        .row_strobe_n_o(ras_n), .column_strobe_n_o(cas_n), .write_enable_n_o(we_n),
        .bank_address_o(bank), .autoprecharge_select_bit_o(ap));
    bank_close_timing dut (.clock_i(clock_i), .reset_i(reset_i), .clock_enable_i(cke),
        .chip_select_n_i(cs_n), .row_strobe_n_i(ras_n), .column_strobe_n_i(cas_n),
        .write_enable_n_i(we_n), .bank_address_i(bank), .autoprecharge_select_bit_i(ap),
        .bank_open_o(bank_open), .bank_precharging_o(bank_prech),
        .auto_precharge_start_o(ap_start), .refresh_busy_o(refresh_busy),
        .refresh_bank_o(refresh_bank), .self_refresh_o(self_refresh),
        .internal_refresh_o(internal_refresh));

    initial begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end

    // ----------------
    // Checks
    // ----------------
    task automatic chk_vec(input logic [3:0] got, input logic [3:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    task automatic chk_in(input int v, input int lo, input int hi, input string m);
        total_checks++;
        if (v < lo || v > hi) begin
            bad_count++;
            $display("MISMATCH %0t %s %0d", $time, m, v);
        end
    endtask
    // Ten cycles also serve as spacing before the next command
    task automatic wait_pulse(input int b, output int n);
        n = 0;
        for (int i = 1; i <= 10; i++) begin
            if (ap_start[b] === 1'b1 && n == 0) n = i;
            @(posedge clock_i);
            #1;
        end
    endtask

    // ----------------
    // Scenarios
    // ----------------
    task automatic t_read_ap();
        ctl.send(CMD_ACTIVATE, 2'h0, 1'b0, 1'b1, G);
        ctl.send(CMD_READ, 2'h0, 1'b1, 1'b1, G);
        wait_pulse(0, k);
        chk_in(k, RD_EDGE, RD_EDGE + RTP_CLKS, "rd ap");
        chk_in(k, PF_EDGE, 10, "rd ap early");
        chk_vec(bank_open, 4'h0, "rd ap open");
    endtask
    task automatic t_write_ap();
        ctl.send(CMD_ACTIVATE, 2'h0, 1'b0, 1'b1, G);
        ctl.send(CMD_WRITE, 2'h0, 1'b1, 1'b1, G);
        wait_pulse(0, k);
        chk_in(k, WR_EDGE, WR_EDGE + 2, "wr ap");
        chk_vec(bank_open, 4'h0, "wr ap open");
    endtask
    task automatic t_plain_read();
        ctl.send(CMD_ACTIVATE, 2'h1, 1'b0, 1'b1, G);
        ctl.send(CMD_READ, 2'h1, 1'b0, 1'b1, G);
        wait_pulse(1, k);
        chk_in(k, 0, 0, "plain rd pulse");
        chk_vec(bank_open, 4'h2, "plain rd open");
        ctl.send(CMD_PRECHARGE, 2'h1, 1'b0, 1'b1, G);
        chk_vec(bank_open, 4'h0, "single pre");
        chk_vec(bank_prech, 4'h2, "pre period");
    endtask
    task automatic t_pre_all();
        ctl.send(CMD_ACTIVATE, 2'h0, 1'b0, 1'b1, G);
        ctl.send(CMD_ACTIVATE, 2'h3, 1'b0, 1'b1, G);
        chk_vec(bank_open, 4'h9, "two open");
        ctl.send(CMD_PRECHARGE, 2'h3, 1'b0, 1'b1, G);
        ctl.send(CMD_PRECHARGE, 2'h3, 1'b1, 1'b1, 1);
        chk_vec(bank_open, 4'h0, "pre all");
    endtask
    task automatic t_refresh();
        repeat (2) begin
            k = int'(refresh_bank);
            ctl.send(CMD_REFRESH, 2'h0, 1'b0, 1'b1, G);
            chk_vec({3'h0, refresh_busy}, 4'h1, "ref busy");
            chk_vec({2'h0, refresh_bank}, {2'h0, 2'(k + 1)}, "ref bank step");
            chk_vec(bank_open, 4'h0, "ref idle");
        end
    endtask
    task automatic t_self();
        k = int'(refresh_bank);
        ctl.send(CMD_REFRESH, 2'h0, 1'b0, 1'b0, G);
        chk_vec({3'h0, self_refresh}, 4'h1, "sr entry");
        chk_vec({3'h0, internal_refresh}, 4'h1, "sr pulse");
        ctl.send(CMD_ACTIVATE, 2'h2, 1'b0, 1'b0, 1);
        chk_vec(bank_open, 4'h0, "sr ignore");
        chk_vec({2'h0, refresh_bank}, {2'h0, 2'(k + 1)}, "sr bank step");
        ctl.send(3'h7, 2'h0, 1'b0, 1'b1, 1);
        k = 0;
        while (self_refresh === 1'b1 && k < 4) begin
            @(posedge clock_i);
            #1;
            k++;
        end
        chk_in(k, 0, 3, "sr exit");
        ctl.send(CMD_ACTIVATE, 2'h2, 1'b0, 1'b1, G);
        chk_vec(bank_open, 4'h4, "act after exit");
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        #300000;
        bad_count++;
        $display("MISMATCH %0t watchdog", $time);
        tally_and_finish();
    end
    initial begin
        reset_i = 1'b1;
        repeat (10) @(posedge clock_i);
        #1;
        reset_i = 1'b0;
        chk_vec(bank_open | ap_start, 4'h0, "reset");
        t_read_ap();
        t_write_ap();
        t_plain_read();
        t_pre_all();
        t_refresh();
        t_self();
        tally_and_finish();
    end
endmodule
